// ---- src/sysexc_pkg.sv ----
package sysexc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_PC_LIMIT  = 8'h04;
  localparam logic [7:0] ADDR_SP_LIMIT  = 8'h08;
  localparam logic [7:0] ADDR_CONTROL   = 8'h0c;

  // ------------------------------------------------------------
  // status and control fields
  // ------------------------------------------------------------
  localparam int BIT_PC_LIMIT   = 0;
  localparam int BIT_SP_LIMIT   = 1;
  localparam int BIT_DIV_ZERO   = 2;
  localparam int BIT_DIV_OVF    = 3;
  localparam int BIT_ILLEGAL    = 4;
  localparam int NUM_FLAGS      = 5;
  localparam int BIT_DBG_BREAK  = 0;

  // ------------------------------------------------------------
  // reset values and constants
  // ------------------------------------------------------------
  localparam logic [31:0] PC_LIMIT_RESET = 32'hffffffff;
  localparam logic [31:0] SP_LIMIT_RESET = 32'h00000000;
  localparam logic [4:0]  FLAGS_RESET    = 5'h0;
  localparam logic [15:0] OP_ILLEGAL     = 16'hffff;
  localparam logic [15:0] OP_DEBUG_BREAK = 16'h0000;
  localparam logic [31:0] EXC_VECTOR     = 32'h00000008;
  localparam logic [31:0] SP_FLAGS_STEP  = 32'h00000001;
  localparam logic [31:0] SP_PC_STEP     = 32'h00000005;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_WAIT   = 3'b001,
    S_FLAGS  = 3'b010,
    S_PC     = 3'b011,
    S_VECTOR = 3'b100,
    S_TRAP   = 3'b101
  } seq_t;

endpackage

// ---- src/system_exception_unit.sv ----
// Operation
// - fetched pc above limit raises pc exception
// - pc exception sets pc limit flag
// - pc flag suppresses repeats; write one clears
// - sp change below limit raises stack exception
// - stack flag set, suppresses repeats, w1c
// - stack exception never blocks stack writes
// - interrupt pushes finish before exception pushes
// - zero divisor raises exception, sets flag
// - divide zero flag suppresses repeats, w1c
// - wide divide overflow raises exception, sets flag
// - divide overflow flag suppresses repeats, w1c
// - unimplemented or all-ones opcode is illegal
// - break opcode illegal when debugger breaks off
// - illegal vectors via quad eight, unincremented pc
// - illegal flag set; no repeat pc push
// - trap vector times four gives quad address
// - trap sets no exception flag
// - trap one fetches reset vector quad
// - push flags at sp-1, pc at sp-6, vector
// - exceptions ignore every enable except the debug break enable for the break opcode
`timescale 1ns/1ps
module system_exception_unit (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // fetch unit
  input  wire logic                 fetchDone,
  input  wire logic [31:0]          fetchPc,
  input  wire logic [15:0]          fetchOpcode,
  input  wire logic                 opUnimplemented,
  // execute unit
  input  wire logic                 instrDone,
  input  wire logic                 spWrite,
  input  wire logic [31:0]          spValue,
  input  wire logic                 divExec,
  input  wire logic                 divZeroDivisor,
  input  wire logic                 wideDivExec,
  input  wire logic                 wideDivOverflow,
  input  wire logic                 irqPushBusy,
  input  wire logic                 trapExec,
  input  wire logic [7:0]           trapVector,
  // stack and program counter control
  output logic                      excBusy,
  output logic                      pushValid,
  output logic                      pushIsFlags,
  output logic [31:0]               pushAddr,
  output logic [31:0]               pushPc,
  output logic                      spLoad,
  output logic [31:0]               spNew,
  output logic                      vecFetch,
  output logic [31:0]               vecAddr
);
  import sysexc_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]          pcLimit;
  logic [31:0]          spLimit;
  logic [4:0]           excFlags;
  logic                 dbgBreakEn;
  logic [4:0]           pendFlags;
  logic [31:0]          savedPc;
  logic [31:0]          sp;
  logic                 pcPushNeeded;
  seq_t                 state;
  seq_t                 next_state;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic                 awHeld;
  logic                 wHeld;
  logic [7:0]           awAddr;
  logic [31:0]          wData;
  logic                 arHeld;
  logic [7:0]           arAddr;

  wire wrFire = awHeld && wHeld && !s_axi_bvalid;
  wire wrOkay = (awAddr == ADDR_STATUS) || (awAddr == ADDR_PC_LIMIT) ||
                (awAddr == ADDR_SP_LIMIT) || (awAddr == ADDR_CONTROL);
  wire rdOkay = (arAddr == ADDR_STATUS) || (arAddr == ADDR_PC_LIMIT) ||
                (arAddr == ADDR_SP_LIMIT) || (arAddr == ADDR_CONTROL);
  wire rdFire = arHeld && !s_axi_rvalid;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !arHeld;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      arHeld <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h00000000;
      arAddr <= 8'h00;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
      if (s_axi_arvalid && !arHeld) begin
        arHeld <= 1'b1;
        arAddr <= s_axi_araddr;
      end else if (rdFire) begin
        arHeld <= 1'b0;
      end
    end
  end

  // strobes are honoured per byte lane on the limit registers
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] nv,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return m;
  endfunction

  logic [3:0] wStrb;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && !wHeld) begin
      wStrb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrOkay ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] rdMux;
  assign rdMux = (arAddr == ADDR_STATUS)   ? {27'h0, excFlags} :
                 (arAddr == ADDR_PC_LIMIT) ? pcLimit :
                 (arAddr == ADDR_SP_LIMIT) ? spLimit :
                 (arAddr == ADDR_CONTROL)  ? {31'h0, dbgBreakEn} : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdOkay ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  wire wrStatus = wrFire && (awAddr == ADDR_STATUS) && wStrb[0];
  wire wrPcLim  = wrFire && (awAddr == ADDR_PC_LIMIT);
  wire wrSpLim  = wrFire && (awAddr == ADDR_SP_LIMIT);
  wire wrCtrl   = wrFire && (awAddr == ADDR_CONTROL) && wStrb[0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pcLimit    <= PC_LIMIT_RESET;
      spLimit    <= SP_LIMIT_RESET;
      dbgBreakEn <= 1'b0;
    end else begin
      if (wrPcLim) pcLimit <= mergeLanes(pcLimit, wData, wStrb);
      if (wrSpLim) spLimit <= mergeLanes(spLimit, wData, wStrb);
      if (wrCtrl)  dbgBreakEn <= wData[BIT_DBG_BREAK];
    end
  end

  // ------------------------------------------------------------
  // detection
  // ------------------------------------------------------------
  // no enable input exists here: only dbgBreakEn masks an exception, for the break opcode
  wire pcOver   = fetchDone && (fetchPc > pcLimit);
  wire spUnder  = spWrite && (spValue < spLimit);
  wire divZero  = divExec && divZeroDivisor;
  wire divide_overflow_flag   = wideDivExec && wideDivOverflow;
  wire illOp    = fetchDone && (opUnimplemented || (fetchOpcode == OP_ILLEGAL) ||
                  ((fetchOpcode == OP_DEBUG_BREAK) && !dbgBreakEn));

  logic [4:0] hits;
  assign hits[BIT_PC_LIMIT] = pcOver;
  assign hits[BIT_SP_LIMIT] = spUnder;
  assign hits[BIT_DIV_ZERO] = divZero;
  assign hits[BIT_DIV_OVF]  = divide_overflow_flag;
  assign hits[BIT_ILLEGAL]  = illOp;

  // a set flag blocks a fresh exception of the same kind
  wire [4:0] newExc = hits & ~excFlags;

  // set wins over the write-one clear in the same cycle
  wire [4:0] clrMask = wrStatus ? wData[4:0] : 5'h00;
  // raw hits re-set a flag so a clear racing an event never loses it
  wire [4:0] next_flags = (excFlags & ~clrMask) | hits;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      excFlags <= FLAGS_RESET;
    end else begin
      excFlags <= next_flags;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  wire anyNew  = |newExc;
  wire launch  = instrDone && !irqPushBusy;
  assign excBusy = (state != S_IDLE);

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:   next_state = anyNew ? S_WAIT : (trapExec ? S_TRAP : S_IDLE);
      S_WAIT:   next_state = launch ? S_FLAGS : S_WAIT;
      S_FLAGS:  next_state = pcPushNeeded ? S_PC : S_VECTOR;
      S_PC:     next_state = S_VECTOR;
      S_VECTOR: next_state = S_IDLE;
      S_TRAP:   next_state = S_IDLE;
      default:  next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state        <= S_IDLE;
      pendFlags    <= FLAGS_RESET;
      savedPc      <= 32'h00000000;
      pcPushNeeded <= 1'b0;
      sp           <= 32'h00000000;
    end else begin
      state <= next_state;
      if (spWrite) sp <= spValue;
      if (state == S_IDLE && anyNew) begin
        pendFlags <= newExc;
        // illegal opcode stacks the address of the opcode itself
        savedPc      <= fetchPc;
        pcPushNeeded <= 1'b1;
      end
      if (state == S_FLAGS) sp <= sp - SP_FLAGS_STEP;
      if (state == S_PC)    sp <= sp - SP_PC_STEP;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // the unit only adds pushes; it never gates the cpu's own writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pushValid   <= 1'b0;
      pushIsFlags <= 1'b0;
      pushAddr    <= 32'h00000000;
      pushPc      <= 32'h00000000;
      spLoad      <= 1'b0;
      spNew       <= 32'h00000000;
      vecFetch    <= 1'b0;
      vecAddr     <= 32'h00000000;
    end else begin
      pushValid   <= (state == S_FLAGS) || (state == S_PC);
      pushIsFlags <= (state == S_FLAGS);
      pushAddr    <= (state == S_FLAGS) ? sp - SP_FLAGS_STEP : sp - SP_PC_STEP;
      pushPc      <= savedPc;
      spLoad      <= (state == S_FLAGS) || (state == S_PC);
      spNew       <= (state == S_FLAGS) ? sp - SP_FLAGS_STEP : sp - SP_PC_STEP;
      vecFetch    <= (state == S_VECTOR) || (state == S_TRAP);
      // trap quad is four times the vector; vector 1 is the reset quad
      vecAddr     <= (state == S_TRAP) ? {22'h0, trapVector, 2'b00}
                                       : EXC_VECTOR;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pc_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    pcOver |=> excFlags[BIT_PC_LIMIT]) else $error("pc limit flag not set");
  a_set_beats_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (newExc[BIT_DIV_ZERO] && wrStatus) |=> excFlags[BIT_DIV_ZERO])
    else $error("clear beat hardware set");
  a_flag_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (excFlags[BIT_DIV_ZERO] && !wrStatus) |=> excFlags[BIT_DIV_ZERO])
    else $error("divide zero flag dropped");
  a_push_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_FLAGS && pcPushNeeded) |=> (state == S_PC) ##1 (state == S_VECTOR))
    else $error("push order wrong");
  a_exc_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_VECTOR) |=> (vecFetch && vecAddr == EXC_VECTOR))
    else $error("wrong exception vector");
  a_trap_quad: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_TRAP) |=> (vecAddr == {22'h0, $past(trapVector), 2'b00}))
    else $error("wrong trap quad");
  a_trap_no_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_TRAP && !anyNew && !wrStatus) |=> $stable(excFlags))
    else $error("trap changed flags");
  a_irq_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == S_WAIT && irqPushBusy) |=> (state == S_WAIT))
    else $error("exception pushed during interrupt");
  a_pc_suppress: assert property (@(posedge core_clk) disable iff (!rst_n)
    excFlags[BIT_PC_LIMIT] |-> !newExc[BIT_PC_LIMIT]) else $error("pc exception repeated");
  a_illegal_op: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fetchDone && fetchOpcode == OP_ILLEGAL) |=> excFlags[BIT_ILLEGAL])
    else $error("all-ones not illegal");

  c_pc_exc:   cover property (@(posedge core_clk) disable iff (!rst_n) pcOver ##[1:20] vecFetch);
  c_stack:    cover property (@(posedge core_clk) disable iff (!rst_n) newExc[BIT_SP_LIMIT]);
  c_trap:     cover property (@(posedge core_clk) disable iff (!rst_n) state == S_TRAP);
  c_clear:    cover property (@(posedge core_clk) disable iff (!rst_n) wrStatus && |excFlags);

endmodule

// ---- bench/cpu_side_model.sv ----
`timescale 1ns/1ps
module cpu_side_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // bench controls
  input  wire logic        slow,
  input  wire logic        irqEntry,
  // from the exception unit
  input  wire logic        excBusy,
  input  wire logic        pushValid,
  input  wire logic        pushIsFlags,
  input  wire logic [31:0] pushAddr,
  input  wire logic [31:0] pushPc,
  input  wire logic        vecFetch,
  input  wire logic [31:0] vecAddr,
  input  wire logic        spLoad,
  input  wire logic [31:0] spNew,
  // back to the exception unit
  output logic             instrDone,
  output logic             irqPushBusy,
  // traffic seen
  output int               nVec,
  output int               badPush,
  output logic [31:0]      lastVec,
  output logic [31:0]      flagsAddr,
  output logic [31:0]      pcAddr,
  output logic [31:0]      pcVal,
  output logic [31:0]      spSeen
);
  int waitCnt;

  // early done while irq pushes run must not start the pushes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      waitCnt     <= 0;
      instrDone   <= 1'b0;
      irqPushBusy <= 1'b0;
      nVec        <= 0;
      badPush     <= 0;
    end else begin
      waitCnt     <= excBusy ? waitCnt + 1 : 0;
      instrDone   <= excBusy && (waitCnt == ((slow || irqEntry) ? 6 : 0)
                     || irqEntry && waitCnt == 2);
      irqPushBusy <= excBusy && irqEntry && waitCnt < 5;
      if (pushValid && irqPushBusy) badPush <= badPush + 1;
      if (pushValid && pushIsFlags) flagsAddr <= pushAddr;
      if (pushValid && !pushIsFlags) begin
        pcAddr <= pushAddr;
        pcVal  <= pushPc;
      end
      if (spLoad) spSeen <= spNew;
      // handler bodies are not run, so no return is ever issued
      if (vecFetch) begin
        nVec    <= nVec + 1;
        lastVec <= vecAddr;
      end
    end
  end
endmodule

// ---- bench/system_exception_unit_bench.sv ----
`timescale 1ns/1ps
module system_exception_unit_bench;
  import sysexc_pkg::*;
  // ------
  // signals
  // ------
  logic        core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, fetchDone, opUnimplemented, instrDone, spWrite, divExec;
  logic        divZeroDivisor, wideDivExec, wideDivOverflow, irqPushBusy, trapExec;
  logic        excBusy, pushValid, pushIsFlags, spLoad, vecFetch, slow, irqEntry;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, trapVector;
  logic [31:0] s_axi_wdata, s_axi_rdata, fetchPc, spValue, pushAddr, pushPc, spNew, vecAddr;
  logic [31:0] lastVec, flagsAddr, pcAddr, pcVal, rd, lim, lastPc, spSeen;
  logic [15:0] fetchOpcode;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          nVec, badPush, n_mismatch, checks, expFlags, v;

  system_exception_unit u_system_exception_unit (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fetchDone, .fetchPc, .fetchOpcode, .opUnimplemented,
    .instrDone, .spWrite, .spValue, .divExec, .divZeroDivisor, .wideDivExec,
    .wideDivOverflow, .irqPushBusy, .trapExec, .trapVector, .excBusy, .pushValid,
    .pushIsFlags, .pushAddr, .pushPc, .spLoad, .spNew, .vecFetch, .vecAddr);
  cpu_side_model u_cpu_side_model (
    .core_clk, .rst_n, .slow, .irqEntry, .excBusy, .pushValid, .pushIsFlags, .pushAddr,
    .pushPc, .vecFetch, .vecAddr, .instrDone, .irqPushBusy, .nVec, .badPush, .lastVec,
    .flagsAddr, .pcAddr, .pcVal, .spLoad, .spNew, .spSeen);

  always #12.5 core_clk = ~core_clk;
  // ------
  // tasks
  // ------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_bready  <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready  <= !wr;
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1'b1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1'b1;
        rs = s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  task automatic status();
    axi(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, 32'(expFlags));
  endtask
  task automatic clr(input logic [31:0] m);
    axi(1'b1, ADDR_STATUS, m);
    chk("clear resp", 32'(rs), 32'(RESP_OKAY));
    expFlags = expFlags & ~int'(m);
  endtask
  task automatic fetch(input logic [31:0] pc, input logic [15:0] op, input logic un);
    @(posedge core_clk);
    fetchDone       <= 1'b1;
    fetchPc         <= pc;
    fetchOpcode     <= op;
    opUnimplemented <= un;
    lastPc = pc;
    @(posedge core_clk);
    fetchDone <= 1'b0;
  endtask
  // k: 0 sp write, 1 divide, 2 wide divide, 3 trap
  task automatic exec(input int k, input logic [31:0] d);
    @(posedge core_clk);
    case (k)
      0: begin
        spWrite <= 1'b1;
        spValue <= d;
      end
      1: begin
        divExec        <= 1'b1;
        divZeroDivisor <= d[0];
      end
      2: begin
        wideDivExec     <= 1'b1;
        wideDivOverflow <= d[0];
      end
      default: begin
        trapExec   <= 1'b1;
        trapVector <= d[7:0];
      end
    endcase
    @(posedge core_clk);
    spWrite     <= 1'b0;
    divExec     <= 1'b0;
    wideDivExec <= 1'b0;
    trapExec    <= 1'b0;
  endtask
  // sp of zero marks a trap, which pushes nothing
  task automatic expectExc(input logic [31:0] vec, input logic [31:0] sp);
    int n0;
    n0 = nVec;
    for (int i = 0; i < 40 && nVec == n0; i++) @(posedge core_clk);
    chk("vector count", 32'(nVec - n0), 32'h1);
    chk("vector address", lastVec, vec);
    if (sp != 0) begin
      chk("flags push", flagsAddr, sp - SP_FLAGS_STEP);
      chk("pc push", pcAddr, sp - SP_FLAGS_STEP - SP_PC_STEP);
      chk("stacked pc", pcVal, lastPc);
      chk("sp after push", spSeen, sp - SP_FLAGS_STEP - SP_PC_STEP);
    end
  endtask
  task automatic noExc();
    int n0;
    n0 = nVec;
    repeat (20) @(posedge core_clk);
    chk("no vector", 32'(nVec - n0), 32'h0);
  endtask
  // ------
  // sequence
  // ------
  initial begin
    #(25ns * 20000);
    chk("watchdog", 32'h0, 32'h1);
    end_sim();
  end
  initial begin
    core_clk = 1'b0;
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {fetchDone, opUnimplemented, spWrite, divExec, divZeroDivisor, wideDivExec} <= '0;
    {wideDivOverflow, trapExec, slow, irqEntry, trapVector, fetchOpcode} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetchPc, spValue} <= '0;
    s_axi_wstrb <= 4'hf;
    lastPc = 32'h0;
    expFlags = 0;
    void'($urandom(32'h92dbd476));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    status();
    axi(1'b0, ADDR_PC_LIMIT, 32'h0);
    chk("pc limit reset", rd, PC_LIMIT_RESET);
    axi(1'b0, ADDR_SP_LIMIT, 32'h0);
    chk("sp limit reset", rd, SP_LIMIT_RESET);
    axi(1'b0, 8'h40, 32'h0);
    chk("unmapped resp", 32'(rs), 32'(RESP_SLVERR));
    $display("test reset_values done");
    lim = ($urandom() & 32'h0fff_ffff) | 32'h0000_1000;
    axi(1'b1, ADDR_PC_LIMIT, lim);
    exec(0, 32'h1000);
    fetch(lim, 16'h1234, 1'b0);
    noExc();
    for (int k = 0; k < 2; k++) begin
      fetch(lim + 1, 16'h1234, 1'b0);
      expectExc(EXC_VECTOR, 32'h1000);
      expFlags = 1;
      status();
      fetch(lim + 2, 16'h1234, 1'b0);
      noExc();
      clr(32'h1);
      status();
      exec(0, 32'h1000);
    end
    $display("test pc_limit done");
    axi(1'b1, ADDR_SP_LIMIT, 32'h0800);
    exec(0, 32'h0800);
    noExc();
    slow <= 1'b1;
    exec(0, 32'h07ff);
    expectExc(EXC_VECTOR, 32'h07ff);
    slow <= 1'b0;
    expFlags = 2;
    exec(0, 32'h07f0);
    noExc();
    status();
    clr(32'h2);
    irqEntry <= 1'b1;
    exec(0, 32'h07fe);
    expectExc(EXC_VECTOR, 32'h07fe);
    chk("push during irq entry", 32'(badPush), 32'h0);
    irqEntry <= 1'b0;
    clr(32'h2);
    $display("test stack_limit done");
    for (int k = 1; k <= 2; k++) begin
      exec(0, 32'h1000);
      exec(k, 32'h0);
      noExc();
      exec(k, 32'h1);
      expectExc(EXC_VECTOR, 32'h1000);
      expFlags = 1 << (k + 1);
      exec(k, 32'h1);
      noExc();
      status();
      clr(32'(expFlags));
      status();
    end
    $display("test divide done");
    for (int k = 0; k < 3; k++) begin
      exec(0, 32'h1000);
      fetch(32'h200 + k, k == 0 ? OP_ILLEGAL : k == 1 ? OP_DEBUG_BREAK : 16'h1234, k == 2);
      expectExc(EXC_VECTOR, 32'h1000);
      expFlags = 16;
      fetch(32'h300, OP_ILLEGAL, 1'b0);
      noExc();
      status();
      clr(32'h10);
    end
    axi(1'b1, ADDR_CONTROL, 32'h1);
    fetch(32'h200, OP_DEBUG_BREAK, 1'b0);
    noExc();
    axi(1'b1, ADDR_CONTROL, 32'h0);
    $display("test illegal done");
    for (int k = 0; k < 3; k++) begin
      v = k == 0 ? 1 : k == 1 ? 255 : $urandom_range(254, 2);
      exec(3, 32'(v));
      expectExc(32'(v) << 2, 32'h0);
      status();
    end
    $display("test trap done");
    end_sim();
  end
endmodule
